// File: design/rps_rec_mem.sv
// record memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module rps_rec_mem #(
	parameter int unsigned W = 8,
	parameter int unsigned DEPTH = 12,
	parameter int unsigned AW = 4
) (
	input wire logic i_clk, // clock
	input wire logic i_rst, // sync reset
	input wire logic i_ce, // clock enable
	input wire logic i_wr, // write strobe
	input wire logic [AW-1:0] i_waddr, // write slot
	input wire logic [W-1:0] i_wdata, // write data
	input wire logic [AW-1:0] i_raddr, // read slot
	output logic [W-1:0] o_rdata // read data, one cycle late
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [W-1:0] rdata;
	} rps_mem_t;

	rps_mem_t r;
	rps_mem_t next_r;

	always_comb begin
		next_r = r;
		if (i_wr && (int'(i_waddr) < DEPTH)) begin
			next_r.mem[i_waddr] = i_wdata;
		end
		if (int'(i_raddr) < DEPTH) begin
			next_r.rdata = r.mem[i_raddr];
		end else begin
			next_r.rdata = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= '0;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_rdata = r.rdata;

endmodule : rps_rec_mem

`default_nettype wire

// File: design/rps_stage.sv
// reverse power protection stage with events, counters and fault records
//
// How it works
// (RQ1) eight setting groups; one shared group select picks the active one
// (RQ2) instant or delayed mode; instant start and trip events share a stamp
// (RQ3) start, trip, blocked outputs each post separate ON and OFF events
// (RQ4) event stamps count whole milliseconds
// (RQ5) cumulative start, trip and blocked counts, clearable by software
// (RQ6) comparator fed by total three-phase power refreshed every 5 ms
// (RQ7) 20 ms running average of power kept as pre-fault record data
// (RQ8) measured-side select chooses which current path feeds the power
// (RQ9) force codes 0 normal, 1 start, 2 trip, 3 blocked, only when enabled
// (RQ10) ratio of measured power to setting computed; pick-up on crossing
// (RQ11) pick-up releases below 97 percent of the setting
// (RQ12) setting in 0.01 kW steps, default 100 kW
// (RQ13) blocking input sampled at cycle start before pick-up evaluation
// (RQ14) pick-up without blocking asserts start and runs the operate timer
// (RQ15) pick-up with blocking asserts blocked and goes no further
// (RQ16) blocking after start drops start; release timing as on reset
// (RQ17) entering blocked raises display and blocking event with start power
// (RQ18) blocking source must arrive 5 ms before operate delay ends
// (RQ19) only definite time operate and reset delay
// (RQ20) user chooses ON, OFF or both events for the event buffer
// (RQ21) twelve latest ON records with stamp, powers, remaining time, group
// (RQ22) condition, expected time, remaining time and ratio readable
// (RQ23) only reverse-direction power magnitude compared; forward never picks up
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.svh"

module rps_stage #(
	parameter int unsigned MS_CYCLES = `RPS_MS_CYCLES
) (
	input wire logic I_CLK, // 100 MHz clock
	input wire logic I_RST, // sync reset, high
	input wire logic I_CE, // clock enable
	input wire logic signed [`RPS_PWR_W-1:0] I_POWER_A, // power, side a
	input wire logic signed [`RPS_PWR_W-1:0] I_POWER_B, // power, side b
	input wire logic I_MEAS_SIDE, // 0 side a, 1 side b
	input wire logic I_POWER_VALID, // new sample, every 5 ms
	input wire logic I_BLOCK, // blocking matrix input
	input wire logic [`RPS_GRP_W-1:0] I_GROUP, // active setting group
	input wire logic I_SET_WR, // setting write strobe
	input wire logic [`RPS_GRP_W-1:0] I_SET_GROUP, // group written
	input wire logic [`RPS_PWR_W-1:0] I_SET_PSET, // pick-up, 0.01 kW
	input wire logic [`RPS_TIME_W-1:0] I_SET_DLY, // operate delay, 5 ms
	input wire logic [`RPS_TIME_W-1:0] I_SET_RDLY, // reset delay, 5 ms
	input wire logic I_INSTANT, // instant mode
	input wire logic I_FORCE_EN, // global stage forcing
	input wire logic [1:0] I_FORCE_CODE, // forced status
	input wire logic [1:0] I_EVT_SEL, // bit0 ON, bit1 OFF stored
	input wire logic I_CNT_CLR, // clear counters
	input wire logic [`RPS_REC_AW-1:0] I_REC_IDX, // record, 0 newest
	output logic O_START, // start output
	output logic O_TRIP, // trip output
	output logic O_BLOCKED, // blocked output
	output logic [`RPS_EV_N-1:0] O_EVT, // event pulses
	output logic [31:0] O_EVT_TIME, // event stamp, ms
	output logic [`RPS_PWR_W-1:0] O_EVT_POWER, // event power
	output logic O_DISP_EVT, // display event pulse
	output logic [`RPS_CNT_W-1:0] O_CNT_START, // start count
	output logic [`RPS_CNT_W-1:0] O_CNT_TRIP, // trip count
	output logic [`RPS_CNT_W-1:0] O_CNT_BLOCK, // blocked count
	output logic [1:0] O_CONDITION, // condition code
	output logic [`RPS_TIME_W-1:0] O_EXP_TIME, // expected time, 5 ms
	output logic [`RPS_TIME_W-1:0] O_REMAIN, // time to trip, 5 ms
	output logic [`RPS_RATIO_W-1:0] O_RATIO, // pm/pset, 0.01
	output logic [`RPS_REC_AW-1:0] O_REC_COUNT, // records held
	output logic [31:0] O_REC_TIME, // record stamp
	output logic [1:0] O_REC_EVENT, // record condition code
	output logic [`RPS_PWR_W-1:0] O_REC_PRETRIG, // pre-trigger power
	output logic [`RPS_PWR_W-1:0] O_REC_FAULT, // fault power
	output logic [`RPS_PWR_W-1:0] O_REC_PREFAULT, // pre-fault power
	output logic [`RPS_TIME_W-1:0] O_REC_REMAIN, // trip time remaining
	output logic [`RPS_GRP_W-1:0] O_REC_GROUP // group in use
);
	import rps_pkg::*;

	localparam int unsigned REC_W = $bits(rps_rec_t);

	rps_regs_t r;
	rps_regs_t next_r;
	rps_rec_t rec_rd;

	logic signed [`RPS_PWR_W-1:0] sel_pwr;
	logic [`RPS_PWR_W-1:0] rev_mag;
	logic [`RPS_PWR_W-1:0] cur_pset;
	logic [`RPS_TIME_W-1:0] cur_dly;
	logic [`RPS_TIME_W-1:0] cur_rdly;
	logic [39:0] pm_x100;
	logic [39:0] set_x100;
	logic [39:0] set_x97;
	logic [39:0] ratio_full;
	logic pick_now;
	logic [`RPS_PWR_W+1:0] hist_sum;
	logic [`RPS_REC_AW:0] raddr_raw;
	logic [`RPS_REC_AW-1:0] raddr;

	// ------------------------------------------------------------------
	// input selection and comparator
	// ------------------------------------------------------------------
	// (RQ8) measured side select
	assign sel_pwr = I_MEAS_SIDE ? I_POWER_B : I_POWER_A;
	// (RQ23) reverse magnitude only
	assign rev_mag = !sel_pwr[`RPS_PWR_W-1] ? '0 :
		(sel_pwr == {1'b1, {(`RPS_PWR_W-1){1'b0}}}) ? `RPS_PWR_MAX :
		`RPS_PWR_W'(-sel_pwr);
	// (RQ1) active group settings
	assign cur_pset = r.pset[I_GROUP];
	assign cur_dly = r.dly[I_GROUP];
	assign cur_rdly = r.rdly[I_GROUP];
	assign pm_x100 = {8'h0, r.pm} * `RPS_PCT;
	assign set_x100 = {8'h0, cur_pset} * `RPS_PCT;
	assign set_x97 = {8'h0, cur_pset} * `RPS_RESET_PCT;
	// (RQ10) pick-up on crossing; (RQ11) release at 97 percent
	assign pick_now = r.picked ? (pm_x100 >= set_x97) : (pm_x100 >= set_x100);
	// (RQ22) ratio in 0.01 steps
	assign ratio_full = pm_x100 / {8'h0, cur_pset};
	// (RQ7) four 5 ms taps form the 20 ms average
	always_comb begin
		hist_sum = '0;
		for (int i = 0; i < `RPS_AVG_TAPS; i++) begin
			hist_sum = hist_sum + {2'h0, r.hist[i]};
		end
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic n_start;
		logic n_trip;
		logic n_blk;
		logic [`RPS_EV_N-1:0] raw;
		logic [`RPS_TIME_W-1:0] load;
		n_start = 1'b0;
		n_trip = 1'b0;
		n_blk = 1'b0;
		raw = '0;
		load = '0;
		next_r = r;
		next_r.sampled = 1'b0;
		next_r.disp = 1'b0;
		next_r.rec_wr = 1'b0;
		next_r.blk_s1 = I_BLOCK;
		next_r.blk_s2 = r.blk_s1;
		next_r.exp_time = cur_dly;

		// (RQ4) millisecond stamp
		if (r.ms_div >= 32'(MS_CYCLES - 1)) begin
			next_r.ms_div = '0;
			next_r.ms = r.ms + 32'h1;
		end else begin
			next_r.ms_div = r.ms_div + 32'h1;
		end

		// (RQ12) group settings, pick-up in 0.01 kW steps
		if (I_SET_WR) begin
			next_r.pset[I_SET_GROUP] = (I_SET_PSET < `RPS_PSET_MIN) ?
				`RPS_PSET_MIN : I_SET_PSET;
			next_r.dly[I_SET_GROUP] = I_SET_DLY;
			next_r.rdly[I_SET_GROUP] = I_SET_RDLY;
		end

		// (RQ6) new power sample; (RQ13) block sampled at cycle start
		if (I_POWER_VALID) begin
			next_r.sampled = 1'b1;
			next_r.pm = rev_mag;
			next_r.prev_pm = r.pm;
			next_r.blk = r.blk_s2;
			for (int i = `RPS_AVG_TAPS - 1; i > 0; i--) begin
				next_r.hist[i] = r.hist[i-1];
			end
			next_r.hist[0] = rev_mag;
		end

		// one evaluation per program cycle
		if (r.sampled) begin
			next_r.picked = pick_now;
			next_r.avg = `RPS_PWR_W'(hist_sum >> `RPS_AVG_SHIFT);
			next_r.ratio = (ratio_full > {23'h0, `RPS_RATIO_MAX}) ?
				`RPS_RATIO_MAX : ratio_full[`RPS_RATIO_W-1:0];
			// (RQ19) definite time operate and reset
			unique case (r.st)
				RPS_IDLE: begin
					if (r.rel != '0) begin
						next_r.rel = r.rel - 1'b1;
					end
					if (pick_now && r.blk) begin
						// (RQ15) blocked, no further processing
						next_r.st = RPS_BLOCKED;
						next_r.blk_power = r.pm;
					end else if (pick_now) begin
						// (RQ14) start and operate timing
						load = (r.rel != '0) ? r.timer : cur_dly;
						// (RQ2) instant mode
						if (I_INSTANT || load == '0) begin
							next_r.st = RPS_TRIP;
							next_r.timer = '0;
						end else begin
							next_r.st = RPS_START;
							next_r.timer = load;
						end
					end
				end
				RPS_START: begin
					if (!pick_now) begin
						next_r.st = RPS_IDLE;
						next_r.rel = cur_rdly;
					end else if (r.blk) begin
						// (RQ16) start drops, release timing runs
						next_r.st = RPS_BLOCKED;
						next_r.rel = cur_rdly;
						next_r.blk_power = r.pm;
					end else if (r.timer <= `RPS_TIME_W'(1)) begin
						next_r.st = RPS_TRIP;
						next_r.timer = '0;
					end else begin
						next_r.timer = r.timer - 1'b1;
					end
				end
				RPS_TRIP: begin
					if (!pick_now || r.blk) begin
						next_r.st = RPS_IDLE;
						next_r.rel = '0;
						next_r.timer = '0;
					end
				end
				RPS_BLOCKED: begin
					if (r.rel != '0) begin
						next_r.rel = r.rel - 1'b1;
					end
					if (!pick_now || !r.blk) begin
						next_r.st = RPS_IDLE;
					end
				end
			endcase
		end

		// (RQ9) forcing overrides the outputs
		if (I_FORCE_EN && I_FORCE_CODE != `RPS_COND_NORMAL) begin
			n_start = (I_FORCE_CODE == `RPS_COND_START) ||
				(I_FORCE_CODE == `RPS_COND_TRIP);
			n_trip = (I_FORCE_CODE == `RPS_COND_TRIP);
			n_blk = (I_FORCE_CODE == `RPS_COND_BLOCKED);
		end else begin
			n_start = (next_r.st == RPS_START) || (next_r.st == RPS_TRIP);
			n_trip = (next_r.st == RPS_TRIP);
			n_blk = (next_r.st == RPS_BLOCKED);
		end
		next_r.out_start = n_start;
		next_r.out_trip = n_trip;
		next_r.out_blk = n_blk;
		next_r.remain = (next_r.st == RPS_START) ? next_r.timer : '0;
		// (RQ22) condition code
		next_r.cond = n_blk ? `RPS_COND_BLOCKED : n_trip ? `RPS_COND_TRIP :
			n_start ? `RPS_COND_START : `RPS_COND_NORMAL;

		// (RQ3) separate on and off edges per output
		raw[`RPS_EV_START_ON] = n_start & ~r.out_start;
		raw[`RPS_EV_START_OFF] = ~n_start & r.out_start;
		raw[`RPS_EV_TRIP_ON] = n_trip & ~r.out_trip;
		raw[`RPS_EV_TRIP_OFF] = ~n_trip & r.out_trip;
		raw[`RPS_EV_BLOCK_ON] = n_blk & ~r.out_blk;
		raw[`RPS_EV_BLOCK_OFF] = ~n_blk & r.out_blk;
		// (RQ20) on/off selection for the event buffer
		for (int i = 0; i < `RPS_EV_N; i += 2) begin
			next_r.evt[i] = raw[i] & I_EVT_SEL[`RPS_SEL_ON];
			next_r.evt[i+1] = raw[i+1] & I_EVT_SEL[`RPS_SEL_OFF];
		end
		// (RQ2) one stamp for all events of a cycle
		next_r.evt_time = r.ms;
		// (RQ17) blocking event carries start power, plus display event
		next_r.evt_power = raw[`RPS_EV_BLOCK_ON] ? next_r.blk_power : next_r.pm;
		next_r.disp = raw[`RPS_EV_BLOCK_ON];

		// (RQ5) counters, a count wins over a same-cycle clear
		for (int i = 0; i < 3; i++) begin
			if (I_CNT_CLR) begin
				next_r.cnt[i] = raw[2*i] ? `RPS_CNT_W'(1) : '0;
			end else begin
				next_r.cnt[i] = r.cnt[i] + `RPS_CNT_W'(raw[2*i]);
			end
		end

		// (RQ21) record on ON events, trip outranks start
		if (raw[`RPS_EV_START_ON] | raw[`RPS_EV_TRIP_ON] | raw[`RPS_EV_BLOCK_ON]) begin
			next_r.rec_wr = 1'b1;
			next_r.rec.stamp = r.ms;
			next_r.rec.code = next_r.cond;
			next_r.rec.pretrig = next_r.prev_pm;
			next_r.rec.fault = next_r.pm;
			// (RQ7) averaged power as pre-fault data
			next_r.rec.prefault = next_r.avg;
			next_r.rec.remain = next_r.remain;
			next_r.rec.group = I_GROUP;
		end
		if (r.rec_wr) begin
			next_r.wptr = (r.wptr == `RPS_REC_AW'(`RPS_REC_DEPTH - 1)) ? '0 :
				r.wptr + 1'b1;
			if (r.nrec != `RPS_REC_AW'(`RPS_REC_DEPTH)) begin
				next_r.nrec = r.nrec + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			r <= '0;
			for (int i = 0; i < `RPS_GROUPS; i++) begin
				r.pset[i] <= `RPS_PSET_DEFAULT;
				r.dly[i] <= `RPS_DLY_DEFAULT;
				r.rdly[i] <= `RPS_RDLY_DEFAULT;
			end
			r.st <= RPS_IDLE;
		end else if (I_CE) begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------------
	// record memory, index 0 is the newest
	// ------------------------------------------------------------------
	assign raddr_raw = {1'b0, r.wptr} + (`RPS_REC_AW+1)'(`RPS_REC_DEPTH - 1) -
		{1'b0, I_REC_IDX};
	assign raddr = (raddr_raw >= (`RPS_REC_AW+1)'(`RPS_REC_DEPTH)) ?
		`RPS_REC_AW'(raddr_raw - (`RPS_REC_AW+1)'(`RPS_REC_DEPTH)) :
		raddr_raw[`RPS_REC_AW-1:0];

	rps_rec_mem #(
		.W(REC_W),
		.DEPTH(`RPS_REC_DEPTH),
		.AW(`RPS_REC_AW)
	) u_rec (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_ce(I_CE),
		.i_wr(r.rec_wr),
		.i_waddr(r.wptr),
		.i_wdata(r.rec),
		.i_raddr(raddr),
		.o_rdata(rec_rd)
	);

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign O_START = r.out_start;
	assign O_TRIP = r.out_trip;
	assign O_BLOCKED = r.out_blk;
	assign O_EVT = r.evt;
	assign O_EVT_TIME = r.evt_time;
	assign O_EVT_POWER = r.evt_power;
	assign O_DISP_EVT = r.disp;
	assign O_CNT_START = r.cnt[0];
	assign O_CNT_TRIP = r.cnt[1];
	assign O_CNT_BLOCK = r.cnt[2];
	assign O_CONDITION = r.cond;
	assign O_EXP_TIME = r.exp_time;
	assign O_REMAIN = r.remain;
	assign O_RATIO = r.ratio;
	assign O_REC_COUNT = r.nrec;
	assign O_REC_TIME = rec_rd.stamp;
	assign O_REC_EVENT = rec_rd.code;
	assign O_REC_PRETRIG = rec_rd.pretrig;
	assign O_REC_FAULT = rec_rd.fault;
	assign O_REC_PREFAULT = rec_rd.prefault;
	assign O_REC_REMAIN = rec_rd.remain;
	assign O_REC_GROUP = rec_rd.group;

endmodule : rps_stage

`default_nettype wire

// File: pkg/rps_defines.svh
// constants of the reverse power protection stage
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH

// ----------------------------------------------------------------------
// widths and sizes
// ----------------------------------------------------------------------
`define RPS_PWR_W 32
`define RPS_TIME_W 19
`define RPS_RATIO_W 17
`define RPS_CNT_W 16
`define RPS_GROUPS 8
`define RPS_GRP_W 3
`define RPS_REC_DEPTH 12
`define RPS_REC_AW 4
`define RPS_AVG_TAPS 4
`define RPS_AVG_SHIFT 2
`define RPS_EV_N 6

// ----------------------------------------------------------------------
// pick-up arithmetic and defaults (power in 0.01 kW units)
// ----------------------------------------------------------------------
`define RPS_PCT 40'h64
`define RPS_RESET_PCT 40'h61
`define RPS_RATIO_MAX 17'h1e848
`define RPS_PSET_DEFAULT 32'h2710
`define RPS_PSET_MIN 32'h1
`define RPS_PWR_MAX 32'h7fffffff
`define RPS_DLY_DEFAULT 19'h0
`define RPS_RDLY_DEFAULT 19'h0

// ----------------------------------------------------------------------
// time base
// ----------------------------------------------------------------------
`define RPS_CLK_PERIOD_NS 10
`define RPS_STAMP_NS 1000000
`define RPS_MS_CYCLES ((`RPS_STAMP_NS + `RPS_CLK_PERIOD_NS - 1) / `RPS_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// condition / force codes and event bit positions
// ----------------------------------------------------------------------
`define RPS_COND_NORMAL 2'h0
`define RPS_COND_START 2'h1
`define RPS_COND_TRIP 2'h2
`define RPS_COND_BLOCKED 2'h3
`define RPS_EV_START_ON 0
`define RPS_EV_START_OFF 1
`define RPS_EV_TRIP_ON 2
`define RPS_EV_TRIP_OFF 3
`define RPS_EV_BLOCK_ON 4
`define RPS_EV_BLOCK_OFF 5
`define RPS_SEL_ON 0
`define RPS_SEL_OFF 1

`endif

// File: pkg/rps_pkg.sv
// types of the reverse power protection stage
`include "rps_defines.svh"

package rps_pkg;

	// ------------------------------------------------------------------
	// stage states, gray along idle-start-trip
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		RPS_IDLE = 2'h0,
		RPS_START = 2'h1,
		RPS_TRIP = 2'h3,
		RPS_BLOCKED = 2'h2
	} rps_state_t;

	// ------------------------------------------------------------------
	// fault record
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] stamp;
		logic [1:0] code;
		logic [`RPS_PWR_W-1:0] pretrig;
		logic [`RPS_PWR_W-1:0] fault;
		logic [`RPS_PWR_W-1:0] prefault;
		logic [`RPS_TIME_W-1:0] remain;
		logic [`RPS_GRP_W-1:0] group;
	} rps_rec_t;

	// ------------------------------------------------------------------
	// state of the stage, record memory apart
	// ------------------------------------------------------------------
	typedef struct packed {
		logic blk_s1;
		logic blk_s2;
		logic blk;
		logic sampled;
		logic [`RPS_GROUPS-1:0][`RPS_PWR_W-1:0] pset;
		logic [`RPS_GROUPS-1:0][`RPS_TIME_W-1:0] dly;
		logic [`RPS_GROUPS-1:0][`RPS_TIME_W-1:0] rdly;
		rps_state_t st;
		logic [`RPS_TIME_W-1:0] timer;
		logic [`RPS_TIME_W-1:0] rel;
		logic [`RPS_AVG_TAPS-1:0][`RPS_PWR_W-1:0] hist;
		logic [`RPS_PWR_W-1:0] pm;
		logic [`RPS_PWR_W-1:0] prev_pm;
		logic [`RPS_PWR_W-1:0] avg;
		logic [`RPS_PWR_W-1:0] blk_power;
		logic [`RPS_RATIO_W-1:0] ratio;
		logic picked;
		logic out_start;
		logic out_trip;
		logic out_blk;
		logic [1:0] cond;
		logic [`RPS_EV_N-1:0] evt;
		logic [31:0] evt_time;
		logic [`RPS_PWR_W-1:0] evt_power;
		logic disp;
		logic [2:0][`RPS_CNT_W-1:0] cnt;
		logic [31:0] ms_div;
		logic [31:0] ms;
		logic [`RPS_TIME_W-1:0] remain;
		logic [`RPS_TIME_W-1:0] exp_time;
		logic rec_wr;
		rps_rec_t rec;
		logic [`RPS_REC_AW-1:0] wptr;
		logic [`RPS_REC_AW-1:0] nrec;
	} rps_regs_t;

endpackage : rps_pkg

// File: sim/rps_front_model.sv
// measurement front end and blocking source model
`timescale 1ns/1ps
`default_nettype none

module rps_front_model #(
	parameter int unsigned PERIOD = 20
) (
	input wire logic i_clk, // clock
	input wire logic signed [31:0] i_pm, // power to deliver
	input wire logic i_side, // side carrying it
	input wire logic i_blk, // block request
	output logic signed [31:0] o_pwr_a, // side a power
	output logic signed [31:0] o_pwr_b, // side b power
	output logic o_valid, // sample strobe
	output logic o_blk // block level
);
	int cnt;
	initial begin
		cnt = 0;
		o_valid = 1'b0;
		o_pwr_a = 32'sh0;
		o_pwr_b = 32'sh0;
		o_blk = 1'b0;
	end
	// ------------------------------------------------------------------
	// program cycle
	// ------------------------------------------------------------------
	// one sample per cycle, idle side garbled
	always @(negedge i_clk) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		o_valid <= (cnt == 0);
		o_pwr_a <= i_side ? (~i_pm ^ cnt) : i_pm;
		o_pwr_b <= i_side ? i_pm : (~i_pm ^ cnt);
	end
	// block level follows the request one clock later
	always @(negedge i_clk) begin
		o_blk <= i_blk;
	end
endmodule : rps_front_model
`default_nettype wire

// File: sim/rps_stage_sva.sv
// port checker for the reverse power stage
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.svh"

module rps_stage_sva (
	input wire logic I_CLK, // clock
	input wire logic I_RST, // sync reset
	input wire logic I_POWER_VALID, // sample strobe
	input wire logic I_FORCE_EN, // forcing enable
	input wire logic [1:0] I_EVT_SEL, // event select
	input wire logic I_CNT_CLR, // counter clear
	input wire logic O_START, // start
	input wire logic O_TRIP, // trip
	input wire logic O_BLOCKED, // blocked
	input wire logic [`RPS_EV_N-1:0] O_EVT, // event pulses
	input wire logic O_DISP_EVT, // display event
	input wire logic [`RPS_CNT_W-1:0] O_CNT_START, // start count
	input wire logic [1:0] O_CONDITION, // condition code
	input wire logic [`RPS_TIME_W-1:0] O_REMAIN, // time to trip
	input wire logic [`RPS_RATIO_W-1:0] O_RATIO, // power ratio
	input wire logic [`RPS_REC_AW-1:0] O_REC_COUNT // records held
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	// ------------------------------------------------------------------
	// steps of an evaluation
	// ------------------------------------------------------------------
	sequence s_unforced;
		!I_FORCE_EN && !$past(I_FORCE_EN, 4);
	endsequence
	sequence s_sampled;
		$past(I_POWER_VALID, 2);
	endsequence
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	AST_START_SRC: assert property ($rose(O_START) ##0 s_unforced |-> s_sampled)
		else $error("start rose without a sample two cycles before");
	AST_COND: assert property (O_CONDITION == (O_BLOCKED ? `RPS_COND_BLOCKED : O_TRIP ?
		`RPS_COND_TRIP : O_START ? `RPS_COND_START : `RPS_COND_NORMAL))
		else $error("condition code disagrees with outputs");
	AST_DISP: assert property (O_DISP_EVT == $rose(O_BLOCKED))
		else $error("display event not tied to blocked rising");
	AST_EVT_PULSE: assert property (|O_EVT |=> O_EVT == '0)
		else $error("event held longer than one cycle");
	AST_EVT_ON: assert property (O_EVT[`RPS_EV_START_ON] |-> $rose(O_START))
		else $error("start on event without start rising");
	AST_EVT_SEL: assert property ($rose(O_START) && $past(I_EVT_SEL[0])
		|-> O_EVT[`RPS_EV_START_ON])
		else $error("selected start on event missing");
	AST_CNT: assert property ($rose(O_START) && !$past(I_CNT_CLR)
		|-> O_CNT_START == $past(O_CNT_START) + 16'h1)
		else $error("start count did not step by one");
	AST_CNT_CLR: assert property ($past(I_CNT_CLR) && !$rose(O_START) |-> O_CNT_START == '0)
		else $error("start count not cleared");
	AST_REMAIN: assert property (!O_START |-> O_REMAIN == '0)
		else $error("time to trip shown outside start");
	AST_RATIO: assert property (O_RATIO <= `RPS_RATIO_MAX)
		else $error("ratio above its ceiling");
	AST_REC: assert property (O_REC_COUNT <= 4'hc)
		else $error("record count above twelve");
endmodule : rps_stage_sva

bind rps_stage rps_stage_sva chk_u (.I_CLK, .I_RST, .I_POWER_VALID, .I_FORCE_EN, .I_EVT_SEL,
	.I_CNT_CLR, .O_START, .O_TRIP, .O_BLOCKED, .O_EVT, .O_DISP_EVT, .O_CNT_START,
	.O_CONDITION, .O_REMAIN, .O_RATIO, .O_REC_COUNT);
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the reverse power stage
`timescale 1ns/1ps
`default_nettype none
`include "rps_defines.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
$display("BAD %s exp %0h got %0h", n, e, a); end end

module tb_top;
	logic clk, rst, side, blk_req, set_wr, instant, force_en, cnt_clr, valid, blk, o_start;
	logic o_trip, o_blocked;
	logic signed [31:0] pm, pa, pb;
	logic [2:0] grp, set_grp, rgrp;
	logic [31:0] set_pset, epw;
	logic [18:0] set_dly, exp_t;
	logic [1:0] force_code, evt_sel, cond, rev;
	logic [5:0] evt;
	logic [15:0] c_st, c_tr, c_bl;
	logic [16:0] ratio;
	logic [3:0] rcnt;
	int bad_count = 0;
	int checks = 0;
	int psets [8];
	int g, pct, mag;
	bit neg, hit;

	rps_front_model #(.PERIOD(20)) front_u (.i_clk(clk), .i_pm(pm), .i_side(side),
		.i_blk(blk_req), .o_pwr_a(pa), .o_pwr_b(pb), .o_valid(valid), .o_blk(blk));
	rps_stage #(.MS_CYCLES(10)) dut_u (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_POWER_A(pa),
		.I_POWER_B(pb), .I_MEAS_SIDE(side), .I_POWER_VALID(valid), .I_BLOCK(blk), .I_GROUP(grp),
		.I_SET_WR(set_wr), .I_SET_GROUP(set_grp), .I_SET_PSET(set_pset), .I_SET_DLY(set_dly),
		.I_SET_RDLY(19'h0), .I_INSTANT(instant), .I_FORCE_EN(force_en),
		.I_FORCE_CODE(force_code), .I_EVT_SEL(evt_sel), .I_CNT_CLR(cnt_clr), .I_REC_IDX(4'h0),
		.O_START(o_start), .O_TRIP(o_trip), .O_BLOCKED(o_blocked), .O_EVT(evt), .O_EVT_TIME(),
		.O_EVT_POWER(epw), .O_DISP_EVT(), .O_CNT_START(c_st), .O_CNT_TRIP(c_tr),
		.O_CNT_BLOCK(c_bl), .O_CONDITION(cond), .O_EXP_TIME(exp_t), .O_REMAIN(),
		.O_RATIO(ratio), .O_REC_COUNT(rcnt), .O_REC_TIME(), .O_REC_EVENT(rev),
		.O_REC_PRETRIG(), .O_REC_FAULT(), .O_REC_PREFAULT(), .O_REC_REMAIN(),
		.O_REC_GROUP(rgrp));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	// wait until the outputs of the next evaluation have landed
	task automatic eval();
		@(posedge clk iff valid);
		@(posedge clk);
		@(negedge clk);
	endtask : eval
	task automatic drive(input int v, input bit b);
		@(negedge clk);
		pm = v;
		blk_req = b;
		eval();
	endtask : drive
	task automatic setg(input int gi, input int p, input int d);
		@(negedge clk);
		set_wr = 1'b1;
		set_grp = 3'(gi);
		set_pset = p;
		set_dly = 19'(d);
		@(negedge clk);
		set_wr = 1'b0;
		tick(1);
	endtask : setg
	function automatic logic [16:0] exp_ratio(input int m, input int p);
		return (m * 100 / p > 125000) ? 17'h1e848 : 17'(m * 100 / p);
	endfunction : exp_ratio
	task automatic end_of_test();
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		end_of_test();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		side = 1'b0;
		blk_req = 1'b0;
		set_wr = 1'b0;
		instant = 1'b0;
		force_en = 1'b0;
		cnt_clr = 1'b0;
		pm = 32'sh0;
		grp = 3'h0;
		set_grp = 3'h0;
		set_pset = 32'h0;
		set_dly = 19'h0;
		force_code = 2'h0;
		evt_sel = 2'h3;
		void'($urandom(32'h7f20));
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		drive(-32'sh270f, 0);
		`CHK("start", 1'b0, o_start)
		drive(-32'sh2710, 0);
		`CHK("start", 1'b1, o_start)
		`CHK("trip", 1'b1, o_trip)
		`CHK("trip_on", 1'b1, evt[`RPS_EV_TRIP_ON])
		`CHK("ratio", 17'h64, ratio)
		drive(-32'sh25e4, 0);
		`CHK("start", 1'b1, o_start)
		drive(-32'sh25e3, 0);
		`CHK("start", 1'b0, o_start)
		`CHK("start_off", 1'b1, evt[`RPS_EV_START_OFF])
		`CHK("trip_off", 1'b1, evt[`RPS_EV_TRIP_OFF])
		`CHK("ratio", exp_ratio(9699, 10000), ratio)
		setg(0, 32'h2710, 3);
		`CHK("exp_time", 19'h3, exp_t)
		for (int k = 0; k < 4; k++) begin
			drive(-32'sh2ee0, 0);
			`CHK("trip", k == 3, o_trip)
		end
		drive(0, 0);
		drive(-32'sh2ee0, 0);
		`CHK("start", 1'b1, o_start)
		drive(-32'sh2ee0, 1);
		`CHK("start", 1'b0, o_start)
		`CHK("blocked", 1'b1, o_blocked)
		`CHK("blk_power", 32'h2ee0, epw)
		tick(3);
		`CHK("rec_event", `RPS_COND_BLOCKED, rev)
		`CHK("rec_group", 3'h0, rgrp)
		drive(0, 0);
		cnt_clr = 1'b1;
		tick(1);
		cnt_clr = 1'b0;
		tick(1);
		`CHK("cnt_start", 16'h0, c_st)
		drive(-32'sh2ee0, 1);
		`CHK("blocked", 1'b1, o_blocked)
		`CHK("start", 1'b0, o_start)
		`CHK("cnt_block", 16'h1, c_bl)
		drive(0, 0);
		instant = 1'b1;
		drive(-32'sh2ee0, 0);
		`CHK("start_on", 1'b1, evt[`RPS_EV_START_ON])
		`CHK("trip_on", 1'b1, evt[`RPS_EV_TRIP_ON])
		`CHK("cnt_trip", 16'h1, c_tr)
		tick(1);
		instant = 1'b0;
		drive(0, 0);
		force_en = 1'b1;
		for (int c = 0; c < 4; c++) begin
			@(negedge clk);
			force_code = c[1:0];
			eval();
			`CHK("forced", c[1:0], cond)
		end
		@(negedge clk);
		force_en = 1'b0;
		eval();
		`CHK("unforced", 2'h0, cond)
		for (int i = 0; i < 8; i++) begin
			psets[i] = $urandom_range(32'h7530, 32'h3e8);
			@(negedge clk);
			grp = 3'(i);
			setg(i, psets[i], 32'h64 + i);
			`CHK("exp_time", 19'(32'h64 + i), exp_t)
		end
		for (int i = 0; i < 30; i++) begin
			g = $urandom_range(7, 0);
			pct = $urandom_range(150, 50);
			if (pct > 95 && pct < 103)
				pct = 150;
			mag = psets[g] * pct / 100;
			neg = 1'($urandom_range(1, 0));
			hit = neg && pct > 100;
			@(negedge clk);
			grp = 3'(g);
			side = 1'($urandom_range(1, 0));
			evt_sel = 2'($urandom_range(3, 0));
			drive(neg ? -mag : mag, 0);
			`CHK("start", hit, o_start)
			if (neg) `CHK("ratio", exp_ratio(mag, psets[g]), ratio)
			if (hit) `CHK("start_on", evt_sel[0], evt[`RPS_EV_START_ON])
			drive(0, 0);
			if (hit) `CHK("start_off", evt_sel[1], evt[`RPS_EV_START_OFF])
		end
		`CHK("rec_count", 4'hc, rcnt)
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
